// ==== src/dual_channel_dma_controller.sv ====
// Two-channel DMA controller with APB register access and local bus master
`timescale 1ns/100ps
module dual_channel_dma_controller #(
  parameter int MIN_BUS_CLKS = dma_pkg::BUS_MIN_CLKS,
  parameter int GAP_CLKS = dma_pkg::DST_GAP_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] transfer_request,
  input wire logic timer2_req,
  output dma_pkg::bus_req_s bus_o,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata,
  output logic [1:0] dma_irq
);
  import dma_pkg::*;

  if (MIN_BUS_CLKS < 2 || MIN_BUS_CLKS > 7) begin : g_bad_bus
    $error("MIN_BUS_CLKS must lie in 2..7");
  end
  if (GAP_CLKS < 1 || GAP_CLKS > 8) begin : g_bad_gap
    $error("GAP_CLKS must lie in 1..8");
  end

  localparam logic [2:0] BUS_LAST = 3'(MIN_BUS_CLKS - 1);
  localparam logic [2:0] GAP_LAST = 3'(GAP_CLKS - 1);

  function automatic logic [19:0] step_addr(input logic [19:0] a, input logic dn,
                                            input logic up, input logic wd);
    logic [19:0] d;
    d = wd ? 20'h00002 : 20'h00001;
    if (up && !dn) begin
      step_addr = a + d;
    end else if (dn && !up) begin
      step_addr = a - d;
    end else begin
      step_addr = a;
    end
  endfunction : step_addr

  logic [19:0] src_q [2];
  logic [19:0] dst_q [2];
  logic [15:0] cnt_q [2];
  logic [15:0] ctl_q [2];
  logic [1:0] rq_s1_q, rq_s2_q, rq_s3_q, rq_q;
  logic [1:0] ready;
  logic [1:0] done;
  logic [1:0] stop;
  logic [1:0] irq_q;
  logic pick, last_q, act_q;
  state_e state_q;
  logic [2:0] bcnt_q;
  logic [2:0] gcnt_q;
  logic ack_q;
  logic bus_fin;
  logic [15:0] data_q;
  bus_req_s bus_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [9:0] idx;
  logic hit, sel_ch, apb_wr;
  logic [3:0] reg_sel;
  logic [15:0] rd_val;
  logic [15:0] cnt_dec;

  // Request pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_s1_q <= 2'b00;
      rq_s2_q <= 2'b00;
      rq_s3_q <= 2'b00;
      rq_q <= 2'b00;
    end else begin
      rq_s1_q <= transfer_request;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      rq_q <= (rq_s2_q & rq_s3_q) | (rq_q & (rq_s2_q | rq_s3_q));
    end
  end

  // APB decode: index is the byte address over four
  assign idx = paddr[11:2];
  assign reg_sel = idx[3:0];
  assign sel_ch = idx[4];
  assign hit = (paddr[1:0] == 2'b00) && (idx[9:8] == 2'b00) &&
               (idx[7:4] == CH0_BASE_HI || idx[7:4] == CH1_BASE_HI) &&
               !idx[0] && (reg_sel <= OFS_CTL);
  assign apb_wr = psel && penable && pready_q && pwrite && hit;

  always_comb begin
    case (reg_sel)
      OFS_SRC_LO: rd_val = src_q[sel_ch][15:0];
      OFS_SRC_HI: rd_val = {12'h000, src_q[sel_ch][19:16]};
      OFS_DST_LO: rd_val = dst_q[sel_ch][15:0];
      OFS_DST_HI: rd_val = {12'h000, dst_q[sel_ch][19:16]};
      OFS_COUNT: rd_val = cnt_q[sel_ch];
      OFS_CTL: rd_val = ctl_q[sel_ch] & CTL_STORE_MASK;
      default: rd_val = 16'h0000;
    endcase
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      if (psel && !penable && !pwrite && hit) begin
        prdata_q <= {16'h0000, rd_val};
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // End of a bus cycle: acknowledged and minimum length reached
  assign bus_fin = ack_q && (bcnt_q >= BUS_LAST);
  assign cnt_dec = cnt_q[act_q] - 16'h0001;

  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_chan
    logic wr;
    logic [15:0] c;
    sync_e sy;
    assign wr = apb_wr && (sel_ch == 1'(ch));
    assign c = ctl_q[ch];
    assign sy = sync_e'(c[CTL_SYNC_LO +: 2]);
    // Timer request is on this clock, so it bypasses the synchroniser
    assign ready[ch] = c[CTL_RUN] && ((sy == SYNC_NONE) ||
                       ((sy == SYNC_SRC || sy == SYNC_DST) &&
                        (rq_q[ch] || (c[CTL_TMR_EN] && timer2_req))));
    assign done[ch] = (state_q == ST_STORE) && bus_fin && (act_q == 1'(ch));
    assign stop[ch] = done[ch] && (cnt_dec == 16'h0000) &&
                      (c[CTL_STOP_CNT] || sy == SYNC_NONE);

    // Software writes win over the engine's step in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_q[ch] <= 20'h00000;
      end else if (wr && reg_sel == OFS_SRC_LO) begin
        src_q[ch][15:0] <= pwdata[15:0];
      end else if (wr && reg_sel == OFS_SRC_HI) begin
        src_q[ch][19:16] <= pwdata[3:0];
      end else if (done[ch]) begin
        src_q[ch] <= step_addr(src_q[ch], c[CTL_SRC_DEC], c[CTL_SRC_INC],
                               c[CTL_WORD]);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dst_q[ch] <= 20'h00000;
      end else if (wr && reg_sel == OFS_DST_LO) begin
        dst_q[ch][15:0] <= pwdata[15:0];
      end else if (wr && reg_sel == OFS_DST_HI) begin
        dst_q[ch][19:16] <= pwdata[3:0];
      end else if (done[ch]) begin
        dst_q[ch] <= step_addr(dst_q[ch], c[CTL_DST_DEC], c[CTL_DST_INC],
                               c[CTL_WORD]);
      end
    end

    // Count always decrements, wrapping from zero gives a 64K run
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[ch] <= 16'h0000;
      end else if (wr && reg_sel == OFS_COUNT) begin
        cnt_q[ch] <= pwdata[15:0];
      end else if (done[ch]) begin
        cnt_q[ch] <= cnt_dec;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_q[ch] <= CTL_RESET;
      end else if (wr && reg_sel == OFS_CTL) begin
        ctl_q[ch] <= pwdata[15:0] & CTL_STORE_MASK;
        ctl_q[ch][CTL_RUN] <= pwdata[CTL_QUAL] ? pwdata[CTL_RUN] : c[CTL_RUN];
      end else if (stop[ch]) begin
        ctl_q[ch][CTL_RUN] <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_q[ch] <= 1'b0;
      end else begin
        irq_q[ch] <= stop[ch] && c[CTL_IRQ_EN];
      end
    end
  end

  // Fixed priority when levels differ, alternate when equal
  always_comb begin
    if (ready == 2'b11) begin
      if (ctl_q[0][CTL_PRIO] != ctl_q[1][CTL_PRIO]) begin
        pick = ctl_q[1][CTL_PRIO];
      end else begin
        pick = !last_q;
      end
    end else begin
      pick = ready[1];
    end
  end

  // Engine: one channel at a time owns the local bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      act_q <= 1'b0;
      last_q <= 1'b1;
      bcnt_q <= 3'h0;
      gcnt_q <= 3'h0;
      ack_q <= 1'b0;
      data_q <= 16'h0000;
      bus_q <= BUS_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ready != 2'b00) begin
            act_q <= pick;
            last_q <= pick;
            state_q <= ST_FETCH;
            bcnt_q <= 3'h0;
            ack_q <= 1'b0;
            bus_q.req <= 1'b1;
            bus_q.write <= 1'b0;
            bus_q.mem <= ctl_q[pick][CTL_SRC_MEM];
            bus_q.word <= ctl_q[pick][CTL_WORD];
            bus_q.addr <= src_q[pick];
          end
        end
        ST_FETCH: begin
          if (bcnt_q != 3'h7) begin
            bcnt_q <= bcnt_q + 3'h1;
          end
          if (bus_q.req && bus_ack) begin
            data_q <= bus_rdata;
            bus_q.req <= 1'b0;
            ack_q <= 1'b1;
          end
          if (bus_fin) begin
            state_q <= ST_STORE;
            bcnt_q <= 3'h0;
            ack_q <= 1'b0;
            bus_q.req <= 1'b1;
            bus_q.write <= 1'b1;
            bus_q.mem <= ctl_q[act_q][CTL_DST_MEM];
            bus_q.word <= ctl_q[act_q][CTL_WORD];
            bus_q.addr <= dst_q[act_q];
            bus_q.wdata <= data_q;
          end
        end
        ST_STORE: begin
          if (bcnt_q != 3'h7) begin
            bcnt_q <= bcnt_q + 3'h1;
          end
          if (bus_q.req && bus_ack) begin
            bus_q.req <= 1'b0;
            ack_q <= 1'b1;
          end
          if (bus_fin) begin
            bus_q.write <= 1'b0;
            gcnt_q <= 3'h0;
            // Destination mode releases the bus so the request can fall
            if (ctl_q[act_q][CTL_SYNC_LO +: 2] == SYNC_DST) begin
              state_q <= ST_GAP;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          gcnt_q <= gcnt_q + 3'h1;
          if (gcnt_q == GAP_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bus_o = bus_q;
  assign dma_irq = irq_q;

endmodule : dual_channel_dma_controller

// ==== src/dma_pkg.sv ====
// Shared constants and types for the two-channel DMA controller
package dma_pkg;

  // Register indices: byte address on APB is four times the index
  localparam logic [3:0] CH0_BASE_HI = 4'hc;
  localparam logic [3:0] CH1_BASE_HI = 4'hd;
  localparam logic [3:0] OFS_SRC_LO = 4'h0;
  localparam logic [3:0] OFS_SRC_HI = 4'h2;
  localparam logic [3:0] OFS_DST_LO = 4'h4;
  localparam logic [3:0] OFS_DST_HI = 4'h6;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [3:0] OFS_CTL = 4'ha;
  localparam logic [7:0] CHAN0_SOURCE_ADDR_LOW = 8'hc0;
  localparam logic [7:0] CHAN0_SOURCE_ADDR_HIGH = 8'hc2;
  localparam logic [7:0] CHAN0_DEST_ADDR_LOW = 8'hc4;
  localparam logic [7:0] CHAN0_DEST_ADDR_HIGH = 8'hc6;
  localparam logic [7:0] CHAN0_TRANSFER_COUNTER = 8'hc8;
  localparam logic [7:0] CHAN0_CONTROL = 8'hca;
  localparam logic [7:0] CHAN1_SOURCE_ADDR_LOW = 8'hd0;
  localparam logic [7:0] CHAN1_SOURCE_ADDR_HIGH = 8'hd2;
  localparam logic [7:0] CHAN1_DEST_ADDR_LOW = 8'hd4;
  localparam logic [7:0] CHAN1_DEST_ADDR_HIGH = 8'hd6;
  localparam logic [7:0] CHAN1_TRANSFER_COUNTER = 8'hd8;
  localparam logic [7:0] CHAN1_CONTROL = 8'hda;

  // Control word bit positions
  localparam int CTL_DST_MEM = 15;
  localparam int CTL_DST_DEC = 14;
  localparam int CTL_DST_INC = 13;
  localparam int CTL_SRC_MEM = 12;
  localparam int CTL_SRC_DEC = 11;
  localparam int CTL_SRC_INC = 10;
  localparam int CTL_STOP_CNT = 9;
  localparam int CTL_IRQ_EN = 8;
  localparam int CTL_SYNC_LO = 6;
  localparam int CTL_PRIO = 5;
  localparam int CTL_TMR_EN = 4;
  localparam int CTL_QUAL = 2;
  localparam int CTL_RUN = 1;
  localparam int CTL_WORD = 0;
  // Bits 3 and 2 are never stored
  localparam logic [15:0] CTL_STORE_MASK = 16'hfff3;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Timing counts in clocks
  localparam int BUS_MIN_CLKS = 4;
  localparam int DST_GAP_CLKS = 2;

  typedef enum logic [1:0] {
    SYNC_NONE = 2'b00,
    SYNC_SRC = 2'b01,
    SYNC_DST = 2'b10,
    SYNC_UNUSED = 2'b11
  } sync_e;

  // Gray sequence idle -> fetch -> store -> gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_STORE = 2'b11,
    ST_GAP = 2'b10
  } state_e;

  typedef struct packed {
    logic req;
    logic write;
    logic mem;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

  localparam bus_req_s BUS_IDLE = '0;

endpackage : dma_pkg

// ==== verification/dma_asserts.sv ====
// Port-level concurrent checks for the DMA controller
`timescale 1ns/100ps
module dma_asserts #(
  parameter int MIN_BUS_CLKS = dma_pkg::BUS_MIN_CLKS,
  parameter int GAP_CLKS = dma_pkg::DST_GAP_CLKS
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input dma_pkg::bus_req_s bus_o,
  input logic bus_ack,
  input logic [1:0] dma_irq
);
  import dma_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fetch_done;
    bus_o.req && !bus_o.write && bus_ack;
  endsequence
  sequence store_start;
    bus_o.req && bus_o.write;
  endsequence
  sequence fetch_start;
    $rose(bus_o.req) && !bus_o.write;
  endsequence
  chk_ready_access: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing in access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read");
  chk_req_hold: assert property (bus_o.req && !bus_ack |=> bus_o.req && $stable(bus_o.addr))
    else $error("bus request dropped before ack");
  chk_req_release: assert property (bus_o.req && bus_ack |=> !bus_o.req)
    else $error("bus request held after ack");
  chk_fetch_store: assert property (fetch_done |=> !bus_o.req ##[1:30] store_start)
    else $error("store did not follow fetch");
  chk_store_early: assert property (fetch_start |=> (!(bus_o.req && bus_o.write)) [*2])
    else $error("store too soon after fetch");
  chk_min_transfer: assert property (fetch_start |=> (!($rose(bus_o.req) && !bus_o.write)) [*7])
    else $error("transfer shorter than eight clocks");
  chk_irq_pulse: assert property (dma_irq[0] |=> !dma_irq[0])
    else $error("channel 0 interrupt not a pulse");
  chk_irq_pulse1: assert property (dma_irq[1] |=> !dma_irq[1])
    else $error("channel 1 interrupt not a pulse");
endmodule : dma_asserts
bind dual_channel_dma_controller dma_asserts #(.MIN_BUS_CLKS(MIN_BUS_CLKS), .GAP_CLKS(GAP_CLKS))
  u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .bus_o,
  .bus_ack, .dma_irq);

// ==== verification/bus_peer.sv ====
// Local bus peripheral model answering fetches and recording stores
`timescale 1ns/100ps
module bus_peer (
  input logic pclk,
  input logic presetn,
  input dma_pkg::bus_req_s bus_o,
  input logic [3:0] wait_clks,
  output logic bus_ack,
  output logic [15:0] bus_rdata,
  output logic [7:0] st_count,
  output dma_pkg::bus_req_s st_last,
  output dma_pkg::bus_req_s ft_last
);
  import dma_pkg::*;
  logic [3:0] wcnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_q <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
      st_count <= 8'h00;
      st_last <= BUS_IDLE;
      ft_last <= BUS_IDLE;
    end else begin
      bus_ack <= 1'b0;
      // Released data lines toggle so stale data never looks valid
      bus_rdata <= ~bus_rdata;
      if (bus_o.req && !bus_ack) begin
        if (wcnt_q == wait_clks) begin
          wcnt_q <= 4'h0;
          bus_ack <= 1'b1;
          if (!bus_o.write) begin
            bus_rdata <= {bus_o.addr[7:0], ~bus_o.addr[7:0]};
            ft_last <= bus_o;
          end else begin
            st_count <= st_count + 8'h01;
            st_last <= bus_o;
          end
        end else begin
          wcnt_q <= wcnt_q + 4'h1;
        end
      end
    end
  end
endmodule : bus_peer

// ==== verification/tb_dual_channel_dma_controller.sv ====
// Register-level bench for the two-channel DMA controller
`timescale 1ns/100ps
module tb_dual_channel_dma_controller;
  import dma_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer2_req, bus_ack, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] transfer_request, dma_irq;
  logic [15:0] bus_rdata, ce;
  logic [3:0] wait_clks;
  logic [7:0] st_count, n0;
  bus_req_s bus_o, st_last, ft_last;
  int err_total = 0, comparisons = 0, cyc = 0, irq0 = 0, irq1 = 0;
  dual_channel_dma_controller #(.MIN_BUS_CLKS(BUS_MIN_CLKS), .GAP_CLKS(DST_GAP_CLKS)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .transfer_request, .timer2_req, .bus_o, .bus_ack, .bus_rdata, .dma_irq);
  bus_peer u_peer (.pclk, .presetn, .bus_o, .wait_clks, .bus_ack, .bus_rdata, .st_count,
    .st_last, .ft_last);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic final_report();
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Slow runs end here instead of hanging the regression
  always @(posedge pclk) begin
    cyc++;
    if (dma_irq[0] === 1'b1) irq0++;
    if (dma_irq[1] === 1'b1) irq1++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready rises; the bench timeout ends a wait that never sees it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(what, exp, q);
  endtask : rdc
  task automatic idle(input logic [7:0] idx);
    repeat (200) begin
      apb(1'b0, idx, 16'h0000);
      if (q[1] === 1'b0) break;
    end
  endtask : idle
  initial begin
    {psel, penable, pwrite, timer2_req} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    transfer_request = 2'b00;
    wait_clks = 4'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctl0", CHAN0_CONTROL, 32'h0);
    rdc("ctl1", CHAN1_CONTROL, 32'h0);
    apb(1'b1, CHAN0_SOURCE_ADDR_HIGH, 16'hffff);
    rdc("srchi", CHAN0_SOURCE_ADDR_HIGH, 32'h000f);
    n0 = st_count;
    apb(1'b1, CHAN0_CONTROL, 16'hffff);
    repeat (30) @(posedge pclk);
    chk("sync11", 32'(n0), 32'(st_count));
    rdc("ctlmask", CHAN0_CONTROL, 32'hfff3);
    apb(1'b1, CHAN0_CONTROL, 16'h0000);
    rdc("runkeep", CHAN0_CONTROL, 32'h0002);
    apb(1'b1, CHAN0_CONTROL, 16'h0004);
    rdc("runstop", CHAN0_CONTROL, 32'h0);
    apb(1'b0, 8'hc1, 16'h0000);
    chk("unmap", 32'h1, {31'h0, e});
    chk("unmapq", 32'h0, q);
    // Unsynchronised words, slow peer, odd destination
    wait_clks <= 4'h2;
    apb(1'b1, CHAN0_SOURCE_ADDR_LOW, 16'h0010);
    apb(1'b1, CHAN0_SOURCE_ADDR_HIGH, 16'h0003);
    apb(1'b1, CHAN0_DEST_ADDR_LOW, 16'h0021);
    apb(1'b1, CHAN0_DEST_ADDR_HIGH, 16'h0005);
    apb(1'b1, CHAN0_TRANSFER_COUNTER, 16'h0002);
    n0 = st_count;
    apb(1'b1, CHAN0_CONTROL, 16'h5507);
    idle(CHAN0_CONTROL);
    chk("ctlend", 32'h5501, q);
    chk("stores", 32'(n0 + 8'd2), 32'(st_count));
    chk("staddr", 32'h5001f, 32'(st_last.addr));
    chk("stdata", 32'h12ed, 32'(st_last.wdata));
    chk("stkind", 32'h5, {29'h0, st_last.write, st_last.mem, st_last.word});
    chk("ftaddr", 32'h30012, 32'(ft_last.addr));
    chk("ftkind", 32'h3, {29'h0, ft_last.write, ft_last.mem, ft_last.word});
    rdc("srclo", CHAN0_SOURCE_ADDR_LOW, 32'h0014);
    rdc("dstlo", CHAN0_DEST_ADDR_LOW, 32'h001d);
    rdc("count", CHAN0_TRANSFER_COUNTER, 32'h0);
    chk("irq0", 32'h1, 32'(irq0));
    // Source-synchronised bytes on channel 1, destination held
    wait_clks <= 4'h0;
    apb(1'b1, CHAN1_SOURCE_ADDR_LOW, 16'h0101);
    apb(1'b1, CHAN1_SOURCE_ADDR_HIGH, 16'h0000);
    apb(1'b1, CHAN1_DEST_ADDR_LOW, 16'h0033);
    apb(1'b1, CHAN1_DEST_ADDR_HIGH, 16'h0002);
    apb(1'b1, CHAN1_TRANSFER_COUNTER, 16'h0003);
    n0 = st_count;
    apb(1'b1, CHAN1_CONTROL, 16'he646);
    repeat (20) @(posedge pclk);
    chk("noreq", 32'(n0), 32'(st_count));
    transfer_request <= 2'b10;
    idle(CHAN1_CONTROL);
    transfer_request <= 2'b00;
    chk("ctl1end", 32'he640, q);
    chk("stores1", 32'(n0 + 8'd3), 32'(st_count));
    chk("staddr1", 32'h20033, 32'(st_last.addr));
    chk("stkind1", 32'h6, {29'h0, st_last.write, st_last.mem, st_last.word});
    chk("stdata1", 32'h03fc, 32'(st_last.wdata));
    chk("ftkind1", 32'h0, {29'h0, ft_last.write, ft_last.mem, ft_last.word});
    rdc("srclo1", CHAN1_SOURCE_ADDR_LOW, 32'h0104);
    chk("irq1", 32'h0, 32'(irq1));
    // Timer-driven channel 0 with no stop at zero: count wraps
    apb(1'b1, CHAN0_TRANSFER_COUNTER, 16'h0001);
    n0 = st_count;
    timer2_req <= 1'b1;
    apb(1'b1, CHAN0_CONTROL, 16'h0046);
    repeat (20) @(posedge pclk);
    chk("notimer", 32'(n0), 32'(st_count));
    apb(1'b1, CHAN0_CONTROL, 16'h0056);
    repeat (60) @(posedge pclk);
    timer2_req <= 1'b0;
    repeat (20) @(posedge pclk);
    rdc("running", CHAN0_CONTROL, 32'h0052);
    apb(1'b1, CHAN0_CONTROL, 16'h0054);
    ce = 16'h0001 - {8'h00, st_count - n0};
    chk("wrapped", 32'h1, {31'h0, (st_count - n0) > 8'd1});
    rdc("cntwrap", CHAN0_TRANSFER_COUNTER, {16'h0000, ce});
    rdc("srchold", CHAN0_SOURCE_ADDR_LOW, 32'h0014);
    // Both channels request at once: channel 0 holds the higher priority
    apb(1'b1, CHAN0_TRANSFER_COUNTER, 16'h0001);
    apb(1'b1, CHAN0_DEST_ADDR_LOW, 16'h0040);
    apb(1'b1, CHAN1_TRANSFER_COUNTER, 16'h0001);
    n0 = st_count;
    apb(1'b1, CHAN0_CONTROL, 16'h0266);
    apb(1'b1, CHAN1_CONTROL, 16'h0246);
    transfer_request <= 2'b11;
    idle(CHAN1_CONTROL);
    transfer_request <= 2'b00;
    chk("prio", 32'h20033, 32'(st_last.addr));
    chk("stores2", 32'(n0 + 8'd2), 32'(st_count));
    rdc("ctl0prio", CHAN0_CONTROL, 32'h0260);
    // Destination-synchronised bytes on channel 1, gap between transfers
    apb(1'b1, CHAN1_TRANSFER_COUNTER, 16'h0002);
    n0 = st_count;
    apb(1'b1, CHAN1_CONTROL, 16'h2286);
    transfer_request <= 2'b10;
    idle(CHAN1_CONTROL);
    transfer_request <= 2'b00;
    chk("ctl1dst", 32'h2280, q);
    chk("stores3", 32'(n0 + 8'd2), 32'(st_count));
    rdc("dstlo1", CHAN1_DEST_ADDR_LOW, 32'h0035);
    // Reset in mid-transfer aborts the channel
    apb(1'b1, CHAN0_TRANSFER_COUNTER, 16'h0010);
    apb(1'b1, CHAN0_CONTROL, 16'h0006);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("rstbus", 32'h0, {31'h0, bus_o.req});
    presetn <= 1'b1;
    rdc("ctlrst", CHAN0_CONTROL, 32'h0);
    repeat (20) @(posedge pclk);
    chk("abort", 32'h0, 32'(st_count));
    final_report();
  end
endmodule : tb_dual_channel_dma_controller
